// file: src/zpc_ctrl.sv
// Behaviour
// - out-of-range factor becomes nearest legal factor
// - factor range 1-200 low models, else 1-1000
// - multi zoom writes factor to every existing trace
// - multi zoom reduces factor to fit all sources
// - illegal factor raises value-out-of-range flag
// - factor query returns applied trace factor
// - zone centre accepted only within divisions 0-10
// - sequence sources keep one zone centre, that of the shown segment
// - multi zoom adds position difference to all existing traces
// - position difference shrunk to keep traces on screen
// - multi zoom adds segment difference to all sequence sources when the addressed source is a sequence
// - segment difference shrunk to stay within counts
// - illegal position raises value-out-of-range flag
// - position command carries segment 1-200
// - segment used only for sequence sources
// - position answer carries segment only if sequence
// - division suffix does not change value
// - position query returns zone centre position
`timescale 1ns/1ps
`default_nettype none
module zpc_ctrl
   import zpc_pkg::*;
#(
   parameter int TRACES = NUM_TRACES
)
(
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic CMD_IS_QUERY,
   input wire logic CMD_KIND,
   input wire logic [1:0] CMD_TRACE,
   input wire logic [15:0] CMD_VALUE,
   input wire logic [7:0] CMD_SEGMENT,
   input wire logic CMD_HAS_SUFFIX,
   input wire logic MULTI_ZOOM,
   input wire logic LOW_RANGE_MODEL,
   input wire logic FOUR_CHANNEL,
   input wire logic [TRACES*16-1:0] SRC_MAX_FACTOR,
   input wire logic [TRACES-1:0] SRC_SEQUENCE,
   input wire logic [TRACES*8-1:0] SRC_SEG_COUNT,
   input wire logic FLAG_CLEAR,
   output logic RSP_VALID,
   output logic [15:0] RSP_VALUE,
   output logic [7:0] RSP_SEGMENT,
   output logic RSP_HAS_SEGMENT,
   output logic VALUE_OUT_OF_RANGE_FLAG,
   output logic [TRACES*16-1:0] TRACE_FACTOR,
   output logic [TRACES*16-1:0] TRACE_POSITION,
   output logic [TRACES*8-1:0] TRACE_SEGMENT
);
   typedef logic signed [VAL_W-1:0] zpc_val_t;

   // usable segment top of a source: count limited to 1..200
   function automatic zpc_val_t seg_top(input logic [7:0] cnt);
      zpc_val_t c;
      c = zpc_val_t'({10'h000, cnt});
      if (c > SEG_MAX)
         c = SEG_MAX;
      if (c < SEG_MIN)
         c = SEG_MIN;
      return c;
   endfunction : seg_top

   zpc_state_t state_ff, nxt_state;
   logic query_ff, nxt_query;
   logic kind_ff, nxt_kind;
   logic [1:0] trace_ff, nxt_trace;
   zpc_val_t value_ff, nxt_value;
   zpc_val_t segreq_ff, nxt_segreq;
   logic rsp_valid_ff, nxt_rsp_valid;
   logic [15:0] rsp_value_ff, nxt_rsp_value;
   logic [7:0] rsp_seg_ff, nxt_rsp_seg;
   logic rsp_hasseg_ff, nxt_rsp_hasseg;
   logic vor_ff, nxt_vor;
   zpc_val_t factor_ff [TRACES];
   zpc_val_t nxt_factor [TRACES];
   zpc_val_t pos_ff [TRACES];
   zpc_val_t nxt_pos [TRACES];
   zpc_val_t seg_ff [TRACES];
   zpc_val_t nxt_seg [TRACES];

   logic [TRACES-1:0] exists;
   logic [TRACES-1:0] affected;
   zpc_val_t factor_hi, f_legal, f_cap, f_final;
   logic f_oor;
   zpc_val_t p_legal, p_diff, p_lo, p_hi, p_step;
   logic p_oor;
   zpc_val_t s_top, s_legal, s_diff, s_lo, s_hi, s_step;
   logic s_oor;
   logic seq_addr;
   logic vor_set;

   // traces three and four exist only on four-channel units
   always_comb
   begin
      for (int i = 0; i < TRACES; i++)
      begin
         exists[i] = (i < BASE_TRACES) || FOUR_CHANNEL;
         affected[i] = exists[i] &&
            (MULTI_ZOOM || (trace_ff == 2'(i)));
      end
   end

   // factor legal range and source capacity
   assign factor_hi = LOW_RANGE_MODEL ? FACTOR_MAX_LOW
                                      : FACTOR_MAX_FULL;
   zpc_clamp u_factor_clamp (
      .val(value_ff),
      .lo(FACTOR_MIN),
      .hi(factor_hi),
      .res(f_legal),
      .oor(f_oor)
   );
   always_comb
   begin
      f_cap = factor_hi;
      for (int i = 0; i < TRACES; i++)
      begin
         if (affected[i] &&
             zpc_val_t'({2'b00, SRC_MAX_FACTOR[i*16 +: 16]}) < f_cap)
            f_cap = zpc_val_t'({2'b00, SRC_MAX_FACTOR[i*16 +: 16]});
      end
      if (f_cap < FACTOR_MIN)
         f_cap = FACTOR_MIN;
      f_final = (f_legal > f_cap) ? f_cap : f_legal;
   end

   // position limited to the screen, then shifted as one difference
   zpc_clamp u_pos_clamp (
      .val(value_ff),
      .lo(POS_MIN),
      .hi(POS_MAX),
      .res(p_legal),
      .oor(p_oor)
   );
   always_comb
   begin
      p_diff = p_legal - pos_ff[trace_ff];
      p_lo = POS_MIN - POS_MAX;
      p_hi = POS_MAX - POS_MIN;
      for (int i = 0; i < TRACES; i++)
      begin
         if (affected[i] && (POS_MIN - pos_ff[i]) > p_lo)
            p_lo = POS_MIN - pos_ff[i];
         if (affected[i] && (POS_MAX - pos_ff[i]) < p_hi)
            p_hi = POS_MAX - pos_ff[i];
      end
   end
   zpc_clamp u_pdiff_clamp (
      .val(p_diff),
      .lo(p_lo),
      .hi(p_hi),
      .res(p_step),
      .oor()
   );

   // segment limited to the addressed source, then shifted together
   assign seq_addr = SRC_SEQUENCE[trace_ff];
   assign s_top = seg_top(SRC_SEG_COUNT[trace_ff*8 +: 8]);
   assign s_oor = (segreq_ff < SEG_MIN) || (segreq_ff > SEG_MAX);
   zpc_clamp u_seg_clamp (
      .val(segreq_ff),
      .lo(SEG_MIN),
      .hi(s_top),
      .res(s_legal),
      .oor()
   );
   always_comb
   begin
      s_diff = s_legal - seg_ff[trace_ff];
      s_lo = SEG_MIN - SEG_MAX;
      s_hi = SEG_MAX - SEG_MIN;
      for (int i = 0; i < TRACES; i++)
      begin
         if (affected[i] && SRC_SEQUENCE[i] &&
             (SEG_MIN - seg_ff[i]) > s_lo)
            s_lo = SEG_MIN - seg_ff[i];
         if (affected[i] && SRC_SEQUENCE[i] &&
             (seg_top(SRC_SEG_COUNT[i*8 +: 8]) - seg_ff[i]) < s_hi)
            s_hi = seg_top(SRC_SEG_COUNT[i*8 +: 8]) - seg_ff[i];
      end
   end
   zpc_clamp u_sdiff_clamp (
      .val(s_diff),
      .lo(s_lo),
      .hi(s_hi),
      .res(s_step),
      .oor()
   );

   assign CMD_READY = (state_ff == ST_IDLE);

   // sequencer, request capture and answers
   always_comb
   begin
      nxt_state = state_ff;
      nxt_query = query_ff;
      nxt_kind = kind_ff;
      nxt_trace = trace_ff;
      nxt_value = value_ff;
      nxt_segreq = segreq_ff;
      nxt_rsp_valid = 1'b0;
      nxt_rsp_value = rsp_value_ff;
      nxt_rsp_seg = rsp_seg_ff;
      nxt_rsp_hasseg = rsp_hasseg_ff;
      vor_set = 1'b0;
      case (state_ff)
         ST_IDLE:
         begin
            if (CMD_VALID)
            begin
               nxt_query = CMD_IS_QUERY;
               nxt_kind = CMD_KIND;
               nxt_trace = CMD_TRACE;
               // suffix flag never enters the value path
               if (CMD_KIND == KIND_FACTOR)
                  nxt_value = zpc_val_t'({2'b00, CMD_VALUE});
               else
                  nxt_value = zpc_val_t'({{2{CMD_VALUE[15]}},
                                          CMD_VALUE});
               nxt_segreq = zpc_val_t'({10'h000, CMD_SEGMENT});
               nxt_state = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            nxt_rsp_valid = 1'b1;
            nxt_state = ST_IDLE;
            if (query_ff && kind_ff == KIND_FACTOR)
            begin
               nxt_rsp_value = factor_ff[trace_ff][15:0];
               nxt_rsp_seg = 8'h00;
               nxt_rsp_hasseg = 1'b0;
            end
            else if (query_ff)
            begin
               nxt_rsp_value = pos_ff[trace_ff][15:0];
               nxt_rsp_seg = seq_addr ? seg_ff[trace_ff][7:0]
                                      : 8'h00;
               nxt_rsp_hasseg = seq_addr;
            end
            else if (kind_ff == KIND_FACTOR)
               vor_set = f_oor;
            else
               vor_set = p_oor || (seq_addr && s_oor);
         end
         default:
            nxt_state = ST_IDLE;
      endcase
      // a set arriving with a clear wins
      nxt_vor = vor_set || (vor_ff && !FLAG_CLEAR);
   end

   // trace settings update on commands
   always_comb
   begin
      for (int i = 0; i < TRACES; i++)
      begin
         nxt_factor[i] = factor_ff[i];
         nxt_pos[i] = pos_ff[i];
         nxt_seg[i] = seg_ff[i];
         if (state_ff == ST_EXEC && !query_ff && affected[i])
         begin
            if (kind_ff == KIND_FACTOR)
               nxt_factor[i] = f_final;
            else
            begin
               // one centre per trace, that of the shown segment
               nxt_pos[i] = pos_ff[i] + p_step;
               if (seq_addr && SRC_SEQUENCE[i])
                  nxt_seg[i] = seg_ff[i] + s_step;
            end
         end
      end
   end

   // state registers
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         state_ff <= ST_IDLE;
         query_ff <= 1'b0;
         kind_ff <= KIND_FACTOR;
         trace_ff <= 2'h0;
         value_ff <= '0;
         segreq_ff <= '0;
         rsp_valid_ff <= 1'b0;
         rsp_value_ff <= 16'h0000;
         rsp_seg_ff <= 8'h00;
         rsp_hasseg_ff <= 1'b0;
         vor_ff <= 1'b0;
         for (int i = 0; i < TRACES; i++)
         begin
            factor_ff[i] <= FACTOR_RST;
            pos_ff[i] <= POS_RST;
            seg_ff[i] <= SEG_RST;
         end
      end
      else
      begin
         state_ff <= nxt_state;
         query_ff <= nxt_query;
         kind_ff <= nxt_kind;
         trace_ff <= nxt_trace;
         value_ff <= nxt_value;
         segreq_ff <= nxt_segreq;
         rsp_valid_ff <= nxt_rsp_valid;
         rsp_value_ff <= nxt_rsp_value;
         rsp_seg_ff <= nxt_rsp_seg;
         rsp_hasseg_ff <= nxt_rsp_hasseg;
         vor_ff <= nxt_vor;
         for (int i = 0; i < TRACES; i++)
         begin
            factor_ff[i] <= nxt_factor[i];
            pos_ff[i] <= nxt_pos[i];
            seg_ff[i] <= nxt_seg[i];
         end
      end
   end

   // outputs
   assign RSP_VALID = rsp_valid_ff;
   assign RSP_VALUE = rsp_value_ff;
   assign RSP_SEGMENT = rsp_seg_ff;
   assign RSP_HAS_SEGMENT = rsp_hasseg_ff;
   assign VALUE_OUT_OF_RANGE_FLAG = vor_ff;
   genvar g;
   generate
      for (g = 0; g < TRACES; g++)
      begin : g_out
         assign TRACE_FACTOR[g*16 +: 16] = factor_ff[g][15:0];
         assign TRACE_POSITION[g*16 +: 16] = pos_ff[g][15:0];
         assign TRACE_SEGMENT[g*8 +: 8] = seg_ff[g][7:0];
      end
   endgenerate
endmodule : zpc_ctrl
`default_nettype wire

// file: src/zpc_pkg.sv
package zpc_pkg;
   // geometry of the trace set
   localparam int NUM_TRACES = 4;
   localparam int BASE_TRACES = 2;
   localparam int VAL_W = 18;
   // magnification limits
   localparam logic signed [VAL_W-1:0] FACTOR_MIN = 18'sh00001;
   localparam logic signed [VAL_W-1:0] FACTOR_MAX_LOW = 18'sh000C8;
   localparam logic signed [VAL_W-1:0] FACTOR_MAX_FULL = 18'sh003E8;
   // position in steps of a hundredth of a division
   localparam int POS_STEPS_PER_DIV = 100;
   localparam int POS_DIV_MIN = 0;
   localparam int POS_DIV_MAX = 10;
   localparam logic signed [VAL_W-1:0] POS_MIN =
      VAL_W'(POS_DIV_MIN * POS_STEPS_PER_DIV);
   localparam logic signed [VAL_W-1:0] POS_MAX =
      VAL_W'(POS_DIV_MAX * POS_STEPS_PER_DIV);
   // segment limits
   localparam logic signed [VAL_W-1:0] SEG_MIN = 18'sh00001;
   localparam logic signed [VAL_W-1:0] SEG_MAX = 18'sh000C8;
   // reset values of the trace state
   localparam logic signed [VAL_W-1:0] FACTOR_RST = 18'sh00001;
   localparam logic signed [VAL_W-1:0] POS_RST = 18'sh001F4;
   localparam logic signed [VAL_W-1:0] SEG_RST = 18'sh00001;
   // position of the out-of-range flag in the status byte
   localparam int STATUS_VOR_BIT = 2;
   // request kinds
   localparam logic KIND_FACTOR = 1'b0;
   localparam logic KIND_POSITION = 1'b1;
   // sequencer states
   typedef enum logic [0:0] {ST_IDLE, ST_EXEC} zpc_state_t;
endpackage : zpc_pkg

// file: src/zpc_clamp.sv
`timescale 1ns/1ps
`default_nettype none
module zpc_clamp
   import zpc_pkg::*;
#(
   parameter int W = VAL_W
)
(
   input wire logic signed [W-1:0] val,
   input wire logic signed [W-1:0] lo,
   input wire logic signed [W-1:0] hi,
   output logic signed [W-1:0] res,
   output logic oor
);
   // limit to the nearest bound and report whether it was needed
   assign oor = (val < lo) || (val > hi);
   assign res = (val < lo) ? lo : ((val > hi) ? hi : val);
endmodule : zpc_clamp
`default_nettype wire

// file: sim/zpc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module zpc_ctrl_chk
   import zpc_pkg::*;
#(
   parameter int TRACES = NUM_TRACES
)
(
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic CMD_VALID,
   input wire logic CMD_READY,
   input wire logic CMD_IS_QUERY,
   input wire logic CMD_KIND,
   input wire logic [15:0] CMD_VALUE,
   input wire logic FLAG_CLEAR,
   input wire logic RSP_VALID,
   input wire logic [7:0] RSP_SEGMENT,
   input wire logic RSP_HAS_SEGMENT,
   input wire logic VALUE_OUT_OF_RANGE_FLAG,
   input wire logic [TRACES*16-1:0] TRACE_FACTOR,
   input wire logic [TRACES*16-1:0] TRACE_POSITION
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   // request taken, then its execute cycle
   sequence s_take;
      CMD_VALID && CMD_READY;
   endsequence
   sequence s_exec;
      s_take ##1 !CMD_READY;
   endsequence
   a_rsp_latency: assert property (s_take |-> ##2 RSP_VALID)
      else $error("answer not two cycles after take");
   a_ready_back: assert property (s_exec |=> CMD_READY)
      else $error("ready not back after execute");
   a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID)
      else $error("answer pulse too long");
   a_flag_sticky: assert property (
      $fell(VALUE_OUT_OF_RANGE_FLAG) |-> $past(FLAG_CLEAR))
      else $error("flag dropped without clear");
   a_factor_flag: assert property (s_take ##0 (!CMD_IS_QUERY &&
      CMD_KIND == KIND_FACTOR && (CMD_VALUE == 16'h0000 ||
      CMD_VALUE > 16'h03E8)) |-> ##2 VALUE_OUT_OF_RANGE_FLAG)
      else $error("illegal factor not flagged");
   a_pos_flag: assert property (s_take ##0 (!CMD_IS_QUERY &&
      CMD_KIND == KIND_POSITION && CMD_VALUE > 16'h03E8)
      |-> ##2 VALUE_OUT_OF_RANGE_FLAG)
      else $error("illegal position not flagged");
   a_factor_range: assert property (
      TRACE_FACTOR[15:0] inside {[16'h0001:16'h03E8]})
      else $error("factor outside range");
   a_pos_range: assert property (TRACE_POSITION[15:0] <= 16'h03E8)
      else $error("position off screen");
   a_seg_answer: assert property (RSP_VALID && RSP_HAS_SEGMENT
      |-> RSP_SEGMENT inside {[8'h01:8'hC8]})
      else $error("answered segment outside range");
endmodule : zpc_ctrl_chk
bind zpc_ctrl zpc_ctrl_chk #(.TRACES(TRACES)) i_zpc_ctrl_chk (.CLOCK,
   .NRST, .CMD_VALID, .CMD_READY, .CMD_IS_QUERY, .CMD_KIND, .CMD_VALUE,
   .FLAG_CLEAR, .RSP_VALID, .RSP_SEGMENT, .RSP_HAS_SEGMENT,
   .VALUE_OUT_OF_RANGE_FLAG, .TRACE_FACTOR, .TRACE_POSITION);
`default_nettype wire

// file: sim/zpc_host.sv
`timescale 1ns/1ps
`default_nettype none
module zpc_host
(
   input wire logic CLOCK,
   input wire logic CMD_READY,
   output logic CMD_VALID,
   output logic CMD_IS_QUERY,
   output logic CMD_KIND,
   output logic [1:0] CMD_TRACE,
   output logic [15:0] CMD_VALUE,
   output logic [7:0] CMD_SEGMENT,
   output logic CMD_HAS_SUFFIX
);
   // idle request lines
   initial
   begin
      {CMD_VALID, CMD_IS_QUERY, CMD_KIND, CMD_HAS_SUFFIX} = 4'h0;
      CMD_TRACE = 2'h0;
      CMD_VALUE = 16'h0000;
      CMD_SEGMENT = 8'h00;
   end
   // hold a request until taken, then let its answer pass
   task automatic send(input logic q, input logic k, input logic [1:0] t,
      input logic [15:0] v, input logic [7:0] s, input logic x);
      int n;
      @(posedge CLOCK);
      CMD_VALID <= 1'b1;
      CMD_IS_QUERY <= q;
      CMD_KIND <= k;
      CMD_TRACE <= t;
      CMD_VALUE <= v;
      CMD_SEGMENT <= s;
      CMD_HAS_SUFFIX <= x;
      n = 0;
      do
      begin
         @(posedge CLOCK);
         n++;
      end
      while (CMD_READY !== 1'b1 && n < 20);
      if (CMD_READY !== 1'b1)
      begin
         $display("[FAIL] %0t request not taken", $time);
         testbench.n_errors++;
         testbench.print_verdict();
      end
      // released lines no longer show the old value
      CMD_VALID <= 1'b0;
      CMD_VALUE <= ~v;
      CMD_SEGMENT <= ~s;
      repeat (3) @(posedge CLOCK);
   endtask : send
endmodule : zpc_host
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import zpc_pkg::*;
;
   logic CLOCK, NRST, MULTI_ZOOM, LOW_RANGE_MODEL, FOUR_CHANNEL, FLAG_CLEAR;
   logic CMD_VALID, CMD_READY, CMD_IS_QUERY, CMD_KIND, CMD_HAS_SUFFIX;
   logic RSP_VALID, RSP_HAS_SEGMENT, VALUE_OUT_OF_RANGE_FLAG;
   logic [1:0] CMD_TRACE;
   logic [3:0] SRC_SEQUENCE;
   logic [7:0] CMD_SEGMENT, RSP_SEGMENT;
   logic [15:0] CMD_VALUE, RSP_VALUE;
   logic [31:0] SRC_SEG_COUNT, TRACE_SEGMENT;
   logic [63:0] SRC_MAX_FACTOR, TRACE_FACTOR, TRACE_POSITION;
   logic [31:0] lfsr = 32'h3C9F;
   int n_errors = 0;
   int cmp_count = 0;
   int q_val[$], q_seg[$], q_flg[$];
   int ev, es, ef;
   int rv;
   logic [1:0] rt;
   zpc_ctrl i_zpc_ctrl (.CLOCK, .NRST, .CMD_VALID, .CMD_READY,
      .CMD_IS_QUERY, .CMD_KIND, .CMD_TRACE, .CMD_VALUE, .CMD_SEGMENT,
      .CMD_HAS_SUFFIX, .MULTI_ZOOM, .LOW_RANGE_MODEL, .FOUR_CHANNEL,
      .SRC_MAX_FACTOR, .SRC_SEQUENCE, .SRC_SEG_COUNT, .FLAG_CLEAR,
      .RSP_VALID, .RSP_VALUE, .RSP_SEGMENT, .RSP_HAS_SEGMENT,
      .VALUE_OUT_OF_RANGE_FLAG, .TRACE_FACTOR, .TRACE_POSITION,
      .TRACE_SEGMENT);
   zpc_host i_zpc_host (.CLOCK, .CMD_READY, .CMD_VALID, .CMD_IS_QUERY,
      .CMD_KIND, .CMD_TRACE, .CMD_VALUE, .CMD_SEGMENT, .CMD_HAS_SUFFIX);
   // 40 MHz clock
   initial
   begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr_next
   // note the expected answer, then issue the request
   task automatic req(input logic q, input logic k, input logic [1:0] t,
      input logic [15:0] v, input logic [7:0] s, input int a, b, f);
      q_val.push_back(a);
      q_seg.push_back(b);
      q_flg.push_back(f);
      lfsr = lfsr_next(lfsr);
      i_zpc_host.send(q, k, t, v, s, lfsr[0]);
   endtask : req
   task automatic clr(input string name);
      FLAG_CLEAR <= 1'b1;
      @(posedge CLOCK);
      FLAG_CLEAR <= 1'b0;
      $display("test %s done", name);
   endtask : clr
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   // compare every answer with the oldest note
   always @(posedge CLOCK)
   begin
      if (RSP_VALID === 1'b1 && q_val.size() > 0)
      begin
         ev = q_val.pop_front();
         es = q_seg.pop_front();
         ef = q_flg.pop_front();
         cmp_count++;
         if ((ev >= 0 && RSP_VALUE !== ev[15:0]) || (es >= 0 &&
            (RSP_SEGMENT !== es[7:0] || RSP_HAS_SEGMENT !== (es != 0)))
            || VALUE_OUT_OF_RANGE_FLAG !== ef[0])
         begin
            $display("[FAIL] %0t answer %0d seg %0d", $time, RSP_VALUE,
               RSP_SEGMENT);
            n_errors++;
         end
      end
   end
   // main sequence
   initial
   begin
      {NRST, MULTI_ZOOM, LOW_RANGE_MODEL, FLAG_CLEAR} = 4'h0;
      SRC_SEQUENCE = 4'h0;
      FOUR_CHANNEL = 1'b0;
      SRC_MAX_FACTOR = {4{16'h03E8}};
      SRC_SEG_COUNT = {4{8'hC8}};
      repeat (20) @(posedge CLOCK);
      NRST <= 1'b1;
      req(0, KIND_FACTOR, 3, 7, 0, -1, -1, 0);
      FOUR_CHANNEL <= 1'b1;
      req(1, KIND_FACTOR, 3, 0, 0, 1, -1, 0);
      req(1, KIND_POSITION, 0, 0, 0, 500, 0, 0);
      req(0, KIND_FACTOR, 1, 5, 0, -1, -1, 0);
      req(1, KIND_FACTOR, 1, 0, 0, 5, -1, 0);
      req(0, KIND_FACTOR, 0, 1500, 0, -1, -1, 1);
      req(1, KIND_FACTOR, 0, 0, 0, 1000, -1, 1);
      clr("reset and factor");
      LOW_RANGE_MODEL <= 1'b1;
      req(0, KIND_FACTOR, 0, 300, 0, -1, -1, 0 + 1);
      req(1, KIND_FACTOR, 0, 0, 0, FACTOR_MAX_LOW, -1, 1);
      clr("low range");
      req(0, KIND_FACTOR, 0, 0, 0, -1, -1, 1);
      req(1, KIND_FACTOR, 0, 0, 0, 1, -1, 1);
      clr("factor zero");
      LOW_RANGE_MODEL <= 1'b0;
      repeat (4)
      begin
         // own copies: the compare process overwrites ev
         rv = lfsr % 1000 + 1;
         rt = lfsr[5:4];
         req(0, KIND_FACTOR, rt, rv[15:0], 0, -1, -1, 0);
         req(1, KIND_FACTOR, rt, 0, 0, rv, -1, 0);
      end
      SRC_MAX_FACTOR[63:48] <= 16'h0032;
      MULTI_ZOOM <= 1'b1;
      req(0, KIND_FACTOR, 0, 100, 0, -1, -1, 0);
      req(1, KIND_FACTOR, 2, 0, 0, 50, -1, 0);
      MULTI_ZOOM <= 1'b0;
      req(0, KIND_POSITION, 0, 300, lfsr[7:0], -1, -1, 0);
      req(1, KIND_POSITION, 0, 0, 0, 300, 0, 0);
      req(0, KIND_POSITION, 0, 16'hFF9C, 8, -1, -1, 1);
      req(1, KIND_POSITION, 0, 0, 0, 0, 0, 1);
      clr("position");
      req(0, KIND_POSITION, 0, 2000, 8, -1, -1, 1);
      req(1, KIND_POSITION, 0, 0, 0, 1000, 0, 1);
      clr("position high");
      req(0, KIND_POSITION, 0, 700, 9, -1, -1, 0);
      MULTI_ZOOM <= 1'b1;
      req(0, KIND_POSITION, 1, 900, 9, -1, -1, 0);
      req(1, KIND_POSITION, 1, 0, 0, 800, 0, 0);
      req(1, KIND_POSITION, 0, 0, 0, 1000, 0, 0);
      MULTI_ZOOM <= 1'b0;
      SRC_SEQUENCE <= 4'hF;
      req(0, KIND_POSITION, 2, 800, 5, -1, -1, 0);
      req(1, KIND_POSITION, 2, 0, 0, 800, 5, 0);
      req(1, KIND_POSITION, 3, 0, 0, 800, 1, 0);
      MULTI_ZOOM <= 1'b1;
      SRC_SEG_COUNT[31:24] <= 8'h0A;
      req(0, KIND_POSITION, 2, 800, 50, -1, -1, 0);
      req(1, KIND_POSITION, 2, 0, 0, 800, 14, 0);
      req(1, KIND_POSITION, 3, 0, 0, 800, 10, 0);
      MULTI_ZOOM <= 1'b0;
      req(0, KIND_POSITION, 2, 800, 250, -1, -1, 1);
      req(1, KIND_POSITION, 2, 0, 0, 800, 200, 1);
      clr("segments");
      repeat (5) @(posedge CLOCK);
      // applied state of every trace after all scenarios
      cmp_count++;
      if (TRACE_FACTOR !== {4{16'h0032}} || TRACE_SEGMENT !==
         {8'h0A, 8'hC8, 8'h0A, 8'h0A} ||
         TRACE_POSITION !== {{3{16'h0320}}, 16'h03E8})
      begin
         $display("[FAIL] %0t trace state wrong", $time);
         n_errors++;
      end
      cmp_count++;
      if (q_val.size() != 0)
      begin
         $display("[FAIL] %0t answers missing", $time);
         n_errors++;
      end
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
